// File: pkg/itlr_pkg.sv
/*
 * Package for the instruction timing and load restart block: register map,
 * field layouts, operation codes, fetch constants and the timing table.
 * Assumes a single 40 MHz clock; all times are held in hundredths of a
 * microsecond (10 ns) and turned into clock cycles inside the block.
 */
package itlr_pkg;

   //////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses)
   localparam logic [7:0] ITLR_OFF_CMD    = 8'h00;
   localparam logic [7:0] ITLR_OFF_LEN    = 8'h04;
   localparam logic [7:0] ITLR_OFF_CNT    = 8'h08;
   localparam logic [7:0] ITLR_OFF_CYCLES = 8'h0c;
   localparam logic [7:0] ITLR_OFF_STATUS = 8'h10;
   localparam logic [7:0] ITLR_OFF_HUND   = 8'h14;

   // Status field positions
   localparam int ITLR_ST_BUSY = 0;
   localparam int ITLR_ST_LOAD = 1;
   localparam int ITLR_ST_PTR  = 16;

   //////////////////////////////////////////////////////////////////////////
   // Operation codes
   typedef enum logic [3:0] {
      ITLR_OP_ADD = 4'h0, ITLR_OP_SUB = 4'h1, ITLR_OP_BRANCH = 4'h2,
      ITLR_OP_CMP = 4'h3, ITLR_OP_DIV = 4'h4, ITLR_OP_EDIT = 4'h5,
      ITLR_OP_XCHG = 4'h6, ITLR_OP_FORMNUM = 4'h7, ITLR_OP_MOVEADR = 4'h8,
      ITLR_OP_MOVECHAR = 4'h9, ITLR_OP_MOVENUM = 4'ha, ITLR_OP_MUL = 4'hb,
      ITLR_OP_READ = 4'hc, ITLR_OP_WRITE = 4'hd
   } itlr_op_t;

   // Branch outcome codes
   localparam logic [2:0] ITLR_BR_NONE = 3'h0;
   localparam logic [2:0] ITLR_BR_A    = 3'h1;
   localparam logic [2:0] ITLR_BR_B    = 3'h2;
   localparam logic [2:0] ITLR_BR_LINK = 3'h3;
   localparam logic [2:0] ITLR_BR_SRQ  = 3'h4;

   //////////////////////////////////////////////////////////////////////////
   // Command word, written at ITLR_OFF_CMD; a write while idle starts a calculation
   typedef struct packed {
      logic [14:0] unused;
      logic        x4_positive;
      logic        file_channel;
      logic        sign_b;
      logic        sign_a;
      logic        mag_a_gt_b;
      logic        identical;
      logic        ind_b;
      logic        ind_a;
      logic        second_operand_index_flag;
      logic        first_operand_index_flag;
      logic [2:0]  branch_kind;
      itlr_op_t    op;
   } itlr_cmd_t;

   typedef struct packed {
      logic [3:0] second_len;
      logic [3:0] first_len;
   } itlr_len_t;

   // Data-dependent counts: cnt_a = Y, S, Z or X3; cnt_b = Z' or X1; cnt_c = X2
   typedef struct packed {
      logic [7:0] cnt_c;
      logic [7:0] cnt_b;
      logic [9:0] cnt_a;
   } itlr_cnt_t;

   // Register port
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        we;
      logic        re;
   } itlr_bus_t;

   // Fetch side events from the memory sequencer
   typedef struct packed {
      logic       load_request;
      logic       power_fail;
      logic       boot_entered;
      logic       fetch_valid;
      logic [5:0] fetch_char;
      logic       instr_done;
   } itlr_fetch_t;

   //////////////////////////////////////////////////////////////////////////
   // Fetch constants
   localparam logic [5:0]  ITLR_CHECK_ABOVE = 6'h09;
   localparam logic [13:0] ITLR_LOAD_ADDR   = 14'h2706;   // 9990
   localparam logic [13:0] ITLR_WRAP_ADDR   = 14'h0000;
   localparam logic [13:0] ITLR_WORD_STEP   = 14'h000a;

   //////////////////////////////////////////////////////////////////////////
   // Time unit and conversion to clock cycles
   localparam int ITLR_HUND_NS  = 10;
   localparam int ITLR_CLK_NS   = 25;
   localparam int ITLR_CONV_GCD = 5;
   localparam logic [31:0] ITLR_CONV_NUM = 32'(ITLR_HUND_NS / ITLR_CONV_GCD);
   localparam logic [3:0]  ITLR_CONV_DEN = 4'(ITLR_CLK_NS / ITLR_CONV_GCD);
   localparam logic [31:0] ITLR_CONV_RND = 32'(ITLR_CLK_NS / ITLR_CONV_GCD / 2);
   localparam logic [5:0]  ITLR_DIV_STEPS = 6'h20;

   // Timing figures in hundredths of a microsecond
   localparam logic [31:0] T_TIX_ONE   = 32'h0000_0c26;   // 31.10
   localparam logic [31:0] T_TIX_BOTH  = 32'h0000_1702;   // 58.90
   localparam logic [31:0] T_IND       = 32'h0000_119e;   // 45.10
   localparam logic [31:0] T_ADD_BASE  = 32'h0000_107c;   // 42.20
   localparam logic [31:0] T_ADD_LA_LE = 32'h0000_014a;   // 3.30
   localparam logic [31:0] T_ADD_LB_LE = 32'h0000_03e8;   // 10.00
   localparam logic [31:0] T_ADD_LA_GT = 32'h0000_044c;   // 11.00
   localparam logic [31:0] T_ADD_LB_GT = 32'h0000_04c4;   // 12.20
   localparam logic [31:0] T_TOD_LB    = 32'h0000_03e8;   // 10.00
   localparam logic [31:0] T_BR_NONE   = 32'h0000_0ec4;   // 37.80
   localparam logic [31:0] T_BR_A      = 32'h0000_0adc;   // 27.80
   localparam logic [31:0] T_BR_B      = 32'h0000_1158;   // 44.40
   localparam logic [31:0] T_BR_LINK   = 32'h0000_15ae;   // 55.50
   localparam logic [31:0] T_BR_SRQ    = 32'h0000_13f6;   // 51.10
   localparam logic [31:0] T_CMP_SAME  = 32'h0000_0fa0;   // 40.00
   localparam logic [31:0] T_CMP_PER   = 32'h0000_030a;   // 7.78
   localparam logic [31:0] T_CMP_DIFF  = 32'h0000_131a;   // 48.90
   localparam logic [31:0] T_DIV_BASE  = 32'h0000_123b;   // 46.67
   localparam logic [31:0] T_DIV_LA    = 32'h0000_006f;   // 1.11
   localparam logic [31:0] T_DIV_LB    = 32'h0000_0a6b;   // 26.67
   localparam logic [31:0] T_DIV_LALB  = 32'h0000_08ae;   // 22.22
   localparam logic [31:0] T_MD_S0     = 32'h0000_03e8;   // 10.00
   localparam logic [31:0] T_MD_SLA    = 32'h0000_0456;   // 11.10
   localparam logic [31:0] T_EDIT_BASE = 32'h0000_100e;   // 41.10
   localparam logic [31:0] T_EDIT_LEN  = 32'h0000_03e8;   // 10.00
   localparam logic [31:0] T_EDIT_X1   = 32'h0000_029b;   // 6.67
   localparam logic [31:0] T_EDIT_X2   = 32'h0000_014d;   // 3.33
   localparam logic [31:0] T_EDIT_X34  = 32'h0000_00de;   // 2.22
   localparam logic [31:0] T_XCH_BASE  = 32'h0000_0f32;   // 38.90
   localparam logic [31:0] T_XCH_PER   = 32'h0000_0532;   // 13.30
   localparam logic [31:0] T_FN_BASE   = 32'h0000_10ea;   // 43.30
   localparam logic [31:0] T_FN_LA     = 32'h0000_014d;   // 3.33
   localparam logic [31:0] T_FN_LB     = 32'h0000_030a;   // 7.78
   localparam logic [31:0] T_FN_Z      = 32'h0000_00de;   // 2.22
   localparam logic [31:0] T_FNO_BASE  = 32'h0000_11cb;   // 45.55
   localparam logic [31:0] T_FNO_LA    = 32'h0000_006f;   // 1.11
   localparam logic [31:0] T_FNO_LB    = 32'h0000_03e8;   // 10.00
   localparam logic [31:0] T_FNO_Z     = 32'h0000_01bc;   // 4.44
   localparam logic [31:0] T_MA_BASE   = 32'h0000_0f32;   // 38.90
   localparam logic [31:0] T_MV_BASE   = 32'h0000_0fa0;   // 40.00
   localparam logic [31:0] T_MV_PER    = 32'h0000_0456;   // 11.10
   localparam logic [31:0] T_MUL_BASE  = 32'h0000_12ac;   // 47.80
   localparam logic [31:0] T_MUL_LA    = 32'h0000_029b;   // 6.67
   localparam logic [31:0] T_MUL_LB    = 32'h0000_03e8;   // 10.00
   localparam logic [31:0] T_IO_TERM   = 32'h0000_2396;   // 91.10
   localparam logic [31:0] T_IO_FILE   = 32'h0000_1ca2;   // 73.30

   // Length rule constants
   localparam logic [31:0] ITLR_LEN_MAX  = 32'h0000_0064;   // 100
   localparam logic [31:0] ITLR_LEN_TENS = 32'h0000_000a;

endpackage : itlr_pkg

// File: logic/itlr_core.sv
/*
 * Instruction timing and load restart core. Computes execution times of
 * instructions from command registers and tracks the fetch pointer and load
 * condition of a 10K partition.
 * Assumes one clock; register port and fetch events come from logic on the
 * same clock, so none of them is synchronised here.
 */
//
// How it works
// - A fetched character counts as check character only above nine.
// - In load condition the fetch pointer sits at 9990, not 0000.
// - Power loss forgets a held load request, not one in the same cycle; restart fetches at 9990.
// - Fetch wraps from the partition top back to 0000.
// - Fetching a check character returns the partition to load condition.
// - Indexing adds 0, 31.1 or 58.9 us for none, one, both.
// - Each indirect operand adds 45.1 us.
// - Add and subtract time depends on which length is larger.
// - Overdraft adds 10.0 us per second length; add: unlike signs.
// - Subtract overdraft: larger first magnitude with like signs.
// - Branch takes 37.8, 27.8, 44.4, 55.5 or 51.1 us by outcome.
// - Compare time: full length if identical, else equal count based.
// - Divide time uses both lengths, their product and quotient digits.
// - Edit time uses lengths, three mask and source counts and an X4 flag.
// - Exchange takes 38.9 plus 13.3 per character.
// - Form numeric has a normal and an improper overflow formula.
// - Move address 38.9, move char and numeric 40.0, plus 11.1 each.
// - Multiply time uses lengths and digit sum of second operand.
// - Terminal read or write 91.1 us, file read 73.3 us.
// - Lengths are tens and units digits; both zero means 100.
//
`timescale 1ns/10ps
`default_nettype none

module itlr_core
   import itlr_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire itlr_bus_t   bus_i,
   input  wire itlr_fetch_t fetch_i,
   output logic [31:0]      rdata_o,
   output logic [13:0]      fetch_addr_o,
   output logic             load_cond_o,
   output logic             busy_o,
   output logic             done_o
);

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [0:0] {
      ITLR_IDLE,
      ITLR_DIVIDE
   } itlr_st_t;

   typedef struct packed {
      itlr_st_t    st;
      itlr_cmd_t   cmd;
      itlr_len_t   lens;
      itlr_cnt_t   cnts;
      logic [13:0] ptr;
      logic        load_cond;
      logic [31:0] hund;
      logic [31:0] div_sh;
      logic [3:0]  rem;
      logic [31:0] quot;
      logic [5:0]  steps;
      logic [31:0] cycles;
      logic [31:0] rdata;
      logic        done;
   } itlr_state_t;

   itlr_state_t s_reg;
   itlr_state_t s_next;

   ////////////////////////////////////////////////////////////////////////////
   // Timing model; pure function of the held command registers
   logic [31:0] la;
   logic [31:0] lb;
   logic [31:0] len_total;
   logic [31:0] cnt_a;
   logic [31:0] cnt_b;
   logic [31:0] cnt_c;
   logic [31:0] index_time_surcharge;
   logic [31:0] tind;
   logic [31:0] overdraft_time_surcharge;
   logic [31:0] tbody;
   logic        overdraft;

   always_comb begin
      la        = 32'(s_reg.lens.first_len);
      lb        = 32'(s_reg.lens.second_len);
      cnt_a     = 32'(s_reg.cnts.cnt_a);
      cnt_b     = 32'(s_reg.cnts.cnt_b);
      cnt_c     = 32'(s_reg.cnts.cnt_c);
      // Both fields zero encodes the maximum length
      if (la == 32'h0 && lb == 32'h0) begin
         len_total = ITLR_LEN_MAX;
      end else begin
         len_total = ITLR_LEN_TENS * la + lb;
      end
      unique case ({s_reg.cmd.first_operand_index_flag,
                    s_reg.cmd.second_operand_index_flag})
         2'b00:   index_time_surcharge = 32'h0;
         2'b11:   index_time_surcharge = T_TIX_BOTH;
         default: index_time_surcharge = T_TIX_ONE;
      endcase
      tind = (s_reg.cmd.ind_a ? T_IND : 32'h0)
           + (s_reg.cmd.ind_b ? T_IND : 32'h0);
      if (s_reg.cmd.op == ITLR_OP_SUB) begin
         overdraft = s_reg.cmd.mag_a_gt_b
                   && (s_reg.cmd.sign_a == s_reg.cmd.sign_b);
      end else begin
         overdraft = s_reg.cmd.mag_a_gt_b
                   && (s_reg.cmd.sign_a != s_reg.cmd.sign_b);
      end
      overdraft_time_surcharge = overdraft ? T_TOD_LB * lb : 32'h0;
      unique case (s_reg.cmd.op)
         ITLR_OP_ADD, ITLR_OP_SUB: begin
            if (la <= lb) begin
               tbody = T_ADD_BASE + T_ADD_LA_LE * la + T_ADD_LB_LE * lb
                     + index_time_surcharge + overdraft_time_surcharge;
            end else begin
               tbody = T_ADD_BASE + T_ADD_LA_GT * la + T_ADD_LB_GT * lb
                     + index_time_surcharge + overdraft_time_surcharge;
            end
         end
         ITLR_OP_BRANCH: begin
            // Branch carries no indexing surcharge
            unique case (s_reg.cmd.branch_kind)
               ITLR_BR_A:    tbody = T_BR_A;
               ITLR_BR_B:    tbody = T_BR_B;
               ITLR_BR_LINK: tbody = T_BR_LINK;
               ITLR_BR_SRQ:  tbody = T_BR_SRQ;
               default:      tbody = T_BR_NONE;
            endcase
         end
         ITLR_OP_CMP: begin
            if (s_reg.cmd.identical) begin
               tbody = T_CMP_SAME + T_CMP_PER * len_total + index_time_surcharge;
            end else begin
               tbody = T_CMP_DIFF + T_CMP_PER * cnt_a + index_time_surcharge;
            end
         end
         ITLR_OP_DIV: begin
            tbody = T_DIV_BASE + T_DIV_LA * la + T_DIV_LB * lb
                  + T_DIV_LALB * la * lb
                  + (T_MD_S0 + T_MD_SLA * la) * cnt_a + index_time_surcharge;
         end
         ITLR_OP_EDIT: begin
            tbody = T_EDIT_BASE + T_EDIT_LEN * (la + lb) + T_EDIT_X1 * cnt_b
                  + T_EDIT_X2 * cnt_c + T_EDIT_X34 * cnt_a
                  + (s_reg.cmd.x4_positive ? T_EDIT_X34 : 32'h0) + index_time_surcharge;
         end
         ITLR_OP_XCHG: begin
            tbody = T_XCH_BASE + T_XCH_PER * len_total + index_time_surcharge;
         end
         ITLR_OP_FORMNUM: begin
            // Compare la - z against lb without going negative
            if (la <= lb + cnt_a) begin
               tbody = T_FN_BASE + T_FN_LA * la + T_FN_LB * lb
                     + T_FN_Z * cnt_a + index_time_surcharge;
            end else begin
               tbody = T_FNO_BASE + T_FNO_LA * la + T_FNO_LB * lb
                     + T_FNO_Z * cnt_b + index_time_surcharge;
            end
         end
         ITLR_OP_MOVEADR: begin
            tbody = T_MA_BASE + T_MV_PER * len_total + index_time_surcharge;
         end
         ITLR_OP_MOVECHAR, ITLR_OP_MOVENUM: begin
            tbody = T_MV_BASE + T_MV_PER * len_total + index_time_surcharge;
         end
         ITLR_OP_MUL: begin
            tbody = T_MUL_BASE + T_MUL_LA * la + T_MUL_LB * lb
                  + (T_MD_S0 + T_MD_SLA * la) * cnt_a + index_time_surcharge;
         end
         ITLR_OP_READ: begin
            tbody = (s_reg.cmd.file_channel ? T_IO_FILE : T_IO_TERM) + index_time_surcharge;
         end
         ITLR_OP_WRITE: begin
            // Only the terminal channel has a write time
            tbody = T_IO_TERM + index_time_surcharge;
         end
         default: begin
            tbody = 32'h0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   logic        start;
   logic [3:0]  rem_t;
   logic        is_check;

   always_comb begin
      s_next   = s_reg;
      s_next.done = 1'b0;
      start    = 1'b0;
      rem_t    = 4'h0;
      is_check = fetch_i.fetch_valid && (fetch_i.fetch_char > ITLR_CHECK_ABOVE);

      // Register writes; parameters are frozen while a result is worked out
      if (bus_i.we && s_reg.st == ITLR_IDLE) begin
         unique case (bus_i.addr)
            ITLR_OFF_CMD: begin
               s_next.cmd = itlr_cmd_t'(bus_i.wdata);
               start      = 1'b1;
            end
            ITLR_OFF_LEN: s_next.lens = itlr_len_t'(bus_i.wdata[7:0]);
            ITLR_OFF_CNT: s_next.cnts = itlr_cnt_t'(bus_i.wdata[25:0]);
            default: ;
         endcase
      end

      unique case (s_reg.st)
         ITLR_IDLE: begin
            if (start) begin
               s_next.st = ITLR_DIVIDE;
            end
         end
         ITLR_DIVIDE: begin
            // First divide cycle latches the total; later ones shift
            if (s_reg.steps == 6'h00) begin
               s_next.hund   = tbody + tind;
               s_next.div_sh = (tbody + tind) * ITLR_CONV_NUM + ITLR_CONV_RND;
               s_next.rem    = 4'h0;
               s_next.quot   = 32'h0;
               s_next.steps  = 6'h01;
            end else begin
               rem_t = {s_reg.rem[2:0], s_reg.div_sh[31]};
               s_next.div_sh = {s_reg.div_sh[30:0], 1'b0};
               if (rem_t >= ITLR_CONV_DEN) begin
                  s_next.rem  = rem_t - ITLR_CONV_DEN;
                  s_next.quot = {s_reg.quot[30:0], 1'b1};
               end else begin
                  s_next.rem  = rem_t;
                  s_next.quot = {s_reg.quot[30:0], 1'b0};
               end
               if (s_reg.steps == ITLR_DIV_STEPS) begin
                  s_next.cycles = s_next.quot;
                  s_next.steps  = 6'h00;
                  s_next.done   = 1'b1;
                  s_next.st     = ITLR_IDLE;
               end else begin
                  s_next.steps = s_reg.steps + 6'h01;
               end
            end
         end
      endcase

      //////////////////////////////////////////////////////////////////////////
      // Fetch pointer and load condition; a set beats a clear in one cycle
      if (fetch_i.instr_done && !s_reg.load_cond) begin
         if (s_reg.ptr >= ITLR_LOAD_ADDR) begin
            s_next.ptr = ITLR_WRAP_ADDR;
         end else begin
            s_next.ptr = s_reg.ptr + ITLR_WORD_STEP;
         end
      end
      if (fetch_i.power_fail || fetch_i.boot_entered) begin
         // Pointer is kept so restart fetches the word at the load address
         s_next.load_cond = 1'b0;
      end
      if (fetch_i.load_request || is_check) begin
         s_next.load_cond = 1'b1;
         s_next.ptr       = ITLR_LOAD_ADDR;
      end
      if (s_next.load_cond) begin
         s_next.ptr = ITLR_LOAD_ADDR;
      end

      //////////////////////////////////////////////////////////////////////////
      // Read data for the cycle after the strobe; unmapped reads give zero
      s_next.rdata = 32'h0;
      if (bus_i.re) begin
         unique case (bus_i.addr)
            ITLR_OFF_CMD:    s_next.rdata = 32'(s_reg.cmd);
            ITLR_OFF_LEN:    s_next.rdata = 32'(s_reg.lens);
            ITLR_OFF_CNT:    s_next.rdata = 32'(s_reg.cnts);
            ITLR_OFF_CYCLES: s_next.rdata = s_reg.cycles;
            ITLR_OFF_STATUS: begin
               s_next.rdata[ITLR_ST_BUSY]              = (s_reg.st != ITLR_IDLE);
               s_next.rdata[ITLR_ST_LOAD]              = s_reg.load_cond;
               s_next.rdata[ITLR_ST_PTR +: 14]         = s_reg.ptr;
            end
            ITLR_OFF_HUND:   s_next.rdata = s_reg.hund;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state flops
   assign rdata_o      = s_reg.rdata;
   assign fetch_addr_o = s_reg.ptr;
   assign load_cond_o  = s_reg.load_cond;
   assign busy_o       = (s_reg.st != ITLR_IDLE);
   assign done_o       = s_reg.done;

endmodule : itlr_core

`default_nettype wire

// File: tb/itlr_core_monitor.sv
/* Checker for itlr_core ports: fetch pointer, load condition, calculation.
   Assumes one clock domain; bound to every itlr_core instance. */
`timescale 1ns/10ps
`default_nettype none
module itlr_core_monitor
   import itlr_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire itlr_bus_t   bus_i,
   input wire itlr_fetch_t fetch_i,
   input wire logic [31:0] rdata_o,
   input wire logic [13:0] fetch_addr_o,
   input wire logic        load_cond_o,
   input wire logic        busy_o,
   input wire logic        done_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic quiet;
   logic chk_char;
   assign quiet = !fetch_i.load_request && !fetch_i.power_fail && !fetch_i.boot_entered
                  && !fetch_i.fetch_valid;
   assign chk_char = fetch_i.fetch_valid && (fetch_i.fetch_char > ITLR_CHECK_ABOVE);
   //////////////////////////////////////////////////////////////////////////////
   sequence cmd_wr;
      bus_i.we && bus_i.addr == ITLR_OFF_CMD && !busy_o;
   endsequence
   sequence calc;
      busy_o[*8] ##[1:40] (done_o && !busy_o);
   endsequence
   chk_calc_span: assert property (cmd_wr |=> calc)
      else $error("calculation did not finish in time");
   chk_check_load: assert property (chk_char |=> load_cond_o && fetch_addr_o == ITLR_LOAD_ADDR)
      else $error("check character did not enter load condition");
   chk_plain_char: assert property (fetch_i.fetch_valid && !chk_char && !fetch_i.load_request
      && !load_cond_o |=> !load_cond_o)
      else $error("plain character entered load condition");
   chk_load_ptr: assert property (load_cond_o |-> fetch_addr_o == ITLR_LOAD_ADDR)
      else $error("pointer off 9990 in load condition");
   chk_load_hold: assert property (load_cond_o && quiet |=> $stable(fetch_addr_o) && load_cond_o)
      else $error("load condition left without cause");
   chk_power_forget: assert property (fetch_i.power_fail && !fetch_i.load_request && !chk_char
      |=> !load_cond_o)
      else $error("load request kept over power loss");
   chk_wrap_top: assert property (fetch_i.instr_done && quiet && !load_cond_o
      && fetch_addr_o == ITLR_LOAD_ADDR |=> fetch_addr_o == ITLR_WRAP_ADDR)
      else $error("pointer did not wrap to 0000");
   chk_word_step: assert property (fetch_i.instr_done && quiet && !load_cond_o
      && fetch_addr_o != ITLR_LOAD_ADDR |=> fetch_addr_o == $past(fetch_addr_o) + ITLR_WORD_STEP)
      else $error("pointer did not step one word");
endmodule : itlr_core_monitor
bind itlr_core itlr_core_monitor itlr_core_monitor_inst (.clk_i(clk_i), .resetn_i(resetn_i),
   .bus_i(bus_i), .fetch_i(fetch_i), .rdata_o(rdata_o), .fetch_addr_o(fetch_addr_o),
   .load_cond_o(load_cond_o), .busy_o(busy_o), .done_o(done_o));
`default_nettype wire

// File: tb/itlr_core_mem.sv
/* Core memory model: first character of the word at the fetch pointer.
   Assumes only 9990 may hold a check character, chosen by check_i. */
`timescale 1ns/10ps
`default_nettype none
module itlr_core_mem
   import itlr_pkg::*;
(
   input  wire logic [13:0] addr_i,
   input  wire logic        check_i,
   output logic [5:0]       char_o
);
   // Plain word holds 9, the largest value that is not a check character
   assign char_o = (check_i && addr_i == ITLR_LOAD_ADDR) ? 6'h0b : 6'h09;
endmodule : itlr_core_mem
`default_nettype wire

// File: tb/itlr_core_test.sv
/* Testbench for itlr_core: timing through the register port, fetch events.
   Assumes the core memory model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module itlr_core_test
   import itlr_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   itlr_bus_t   bus_i = '0;
   itlr_fetch_t fetch_i = '0;
   logic [31:0] rdata_o;
   logic [13:0] fetch_addr_o;
   logic        load_cond_o;
   logic        busy_o;
   logic        done_o;
   logic        check_mem = 1'b0;
   logic [5:0]  mem_char;
   int          miscompares = 0;
   int          comparisons = 0;
   int          ticks = 0;
   int          br[5] = '{3780, 2780, 4440, 5550, 5110};
   itlr_core itlr_core_inst (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .fetch_i(fetch_i),
      .rdata_o(rdata_o), .fetch_addr_o(fetch_addr_o), .load_cond_o(load_cond_o),
      .busy_o(busy_o), .done_o(done_o));
   itlr_core_mem itlr_core_mem_inst (.addr_i(fetch_addr_o), .check_i(check_mem), .char_o(mem_char));
   always #12.5 clk_i = ~clk_i;
   //////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      bus_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk_i);
      bus_i.we <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge clk_i);
      bus_i <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      @(posedge clk_i);
      bus_i.re <= 1'b0;
      #1 chk(nm, e, rdata_o);
   endtask : rd
   // Second command lands while busy and must be dropped
   task automatic run(input logic [31:0] c, input logic [7:0] l, input logic [25:0] n, input int h);
      int w;
      wr(ITLR_OFF_LEN, {24'h0, l});
      wr(ITLR_OFF_CNT, {6'h0, n});
      wr(ITLR_OFF_CMD, c);
      wr(ITLR_OFF_CMD, 32'h2);
      for (w = 0; w < 100 && done_o !== 1'b1; w++) begin
         @(posedge clk_i);
         #1;
      end
      chk("done", 32'h1, {31'h0, done_o});
      rd(ITLR_OFF_CMD, c, "cmd");
      rd(ITLR_OFF_HUND, 32'(h), "hund");
      rd(ITLR_OFF_CYCLES, 32'((2 * h + 2) / 5), "cycles");
   endtask : run
   task automatic ev(input logic [4:0] f, input logic ld, input logic [13:0] ad);
      @(posedge clk_i);
      fetch_i <= {f[4:1], mem_char, f[0]};
      @(posedge clk_i);
      fetch_i <= '0;
      #1 chk("load_cond", {31'h0, ld}, {31'h0, load_cond_o});
      chk("fetch_addr", {18'h0, ad}, {18'h0, fetch_addr_o});
   endtask : ev
   task automatic end_sim();
      if (miscompares == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   //////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i) begin
      ticks <= ticks + 1;
      if (ticks == 5000) begin
         miscompares++;
         end_sim();
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(ITLR_OFF_STATUS, 32'h0, "status");
      rd(8'h20, 32'h0, "unmapped");
      ev(5'h01, 1'b0, 14'd10);
      ev(5'h10, 1'b1, 14'd9990);
      rd(ITLR_OFF_STATUS, {2'h0, ITLR_LOAD_ADDR, 14'h0, 2'b10}, "status");
      ev(5'h01, 1'b1, 14'd9990);
      ev(5'h08, 1'b0, 14'd9990);
      ev(5'h02, 1'b0, 14'd9990);
      check_mem <= 1'b1;
      ev(5'h02, 1'b1, 14'd9990);
      ev(5'h04, 1'b0, 14'd9990);
      ev(5'h01, 1'b0, 14'd0);
      ev(5'h01, 1'b0, 14'd10);
      run(32'h780, 8'h32, 26'h0, 22790);
      run(32'h100, 8'h11, 26'h0, 8660);
      run(32'h3000, 8'h35, 26'h0, 16380);
      run(32'h7000, 8'h35, 26'h0, 13380);
      run(32'h7001, 8'h35, 26'h0, 16380);
      run(32'h3001, 8'h35, 26'h0, 13380);
      for (int k = 0; k < 5; k++)
         run(32'h82 | (32'(k) << 4), 8'h0, 26'h0, br[k]);
      run(32'h883, 8'h21, 26'h0, 16446);
      run(32'h3, 8'h21, 26'h4, 8002);
      run(32'h4, 8'h32, 26'h5, 42322);
      run(32'h10005, 8'h21, 26'h40803, 9665);
      run(32'h6, 8'h00, 26'h0, 136890);
      run(32'h7, 8'h25, 26'h3, 8217);
      run(32'h7, 8'h26, 26'h801, 8109);
      run(32'h8, 8'h01, 26'h0, 14990);
      run(32'h89, 8'h50, 26'h0, 12660);
      run(32'ha, 8'h12, 26'h0, 27310);
      run(32'hb, 8'h12, 26'h3, 16774);
      run(32'h20c, 8'h0, 26'h0, 13620);
      run(32'h800c, 8'h0, 26'h0, 7330);
      run(32'h800d, 8'h0, 26'h0, 9110);
      end_sim();
   end
endmodule : itlr_core_test
`default_nettype wire
